// ===== bench/glyph_mem_model.sv
`default_nettype none
module glyph_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic slow_i,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_ff;
  logic [7:0] byte_val;
  // each byte depends on all low address bits, so a wrong address shows as wrong dots
  assign byte_val = mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ mem_addr_i[23:16] ^ 8'h5A;
  // outside the ack cycle the bus shows the inverse, never a stale good byte
  assign mem_rdata_o = mem_ack_o ? byte_val : ~byte_val;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ack_o <= 1'b0;
      wait_ff <= 3'h0;
    end else if (mem_req_i && !mem_ack_o && wait_ff == (slow_i ? 3'h5 : 3'h0)) begin
      mem_ack_o <= 1'b1;
      wait_ff <= 3'h0;
    end else begin
      mem_ack_o <= 1'b0;
      wait_ff <= (mem_req_i && !mem_ack_o) ? wait_ff + 3'h1 : 3'h0;
    end
  end
endmodule : glyph_mem_model
`default_nettype wire

// ===== bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic pix_ready_i = 1'b1;
  logic stall = 1'b0;
  logic [2:0] cyc = 3'h0;
  logic [31:0] prdata_o, mem_addr_o;
  logic pready_o, pslverr_o, mem_req_o, mem_ack_i, pix_valid_o, busy_o;
  logic [7:0] mem_rdata_i;
  logic [4:0] pix_x_o, pix_y_o;
  logic [23:0] pix_colour_o;
  logic [33:0] dq[$];
  logic [31:0] aq[$];
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [23:0] FG = 24'hC3_81_E7;
  localparam logic [23:0] BG = 24'h1E_66_24;
  localparam logic [31:0] BASE = 32'h0012_3400;

  user_glyph_code_resolver #(.ADDR_W(32)) i_user_glyph_code_resolver (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .pix_valid_o(pix_valid_o),
    .pix_ready_i(pix_ready_i), .pix_x_o(pix_x_o), .pix_y_o(pix_y_o), .pix_colour_o(pix_colour_o),
    .busy_o(busy_o));
  glyph_mem_model i_glyph_mem_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .slow_i(stall), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // the display side stalls three cycles in four while stall is set
  always @(posedge clk_i) begin
    cyc <= cyc + 3'h1;
    pix_ready_i <= stall ? (cyc[1:0] == 2'b00) : 1'b1;
  end
  // record every accepted dot and every fetched byte address
  always @(negedge clk_i) begin
    if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1) dq.push_back({pix_x_o, pix_y_o, pix_colour_o});
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) aq.push_back(mem_addr_o);
  end

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic hang(input string what);
    n_errors++;
    $display("MISMATCH t=%0t timeout %s", $time, what);
    close_out();
  endtask : hang

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    if (i == 16) hang("apb");
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, idx, 32'h0, rd, e);
    check({2'b00, rd}, {2'b00, exp}, "read data");
    check({33'h0, e}, {33'h0, experr}, "slave error");
  endtask : rdchk

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, idx, d, rd, e);
  endtask : wr

  // colours reset to zero, hold 8 bits, and an unmapped word errors and reads zero
  task automatic t_regs;
    int i;
    for (i = 0; i < 6; i++) rdchk(glyph_resolver_pkg::IDX_FG0 + 10'(i), 32'h0, 1'b0);
    for (i = 0; i < 3; i++) begin
      wr(glyph_resolver_pkg::IDX_FG0 + 10'(i), {24'hFFFF_FF, FG[8*i+:8]});
      wr(glyph_resolver_pkg::IDX_BG0 + 10'(i), {24'hFFFF_FF, BG[8*i+:8]});
      rdchk(glyph_resolver_pkg::IDX_FG0 + 10'(i), {24'h0, FG[8*i+:8]}, 1'b0);
      rdchk(glyph_resolver_pkg::IDX_BG0 + 10'(i), {24'h0, BG[8*i+:8]}, 1'b0);
    end
    wr(glyph_resolver_pkg::IDX_BASE, BASE);
    rdchk(10'h0E0, 32'h0, 1'b1);
  endtask : t_regs

  // one glyph end to end: busy, refused second code, fetch addresses, every dot
  task automatic t_glyph(input logic [1:0] sz, input logic [15:0] code, input int bpg, input int w);
    logic [31:0] a;
    logic [7:0] d;
    int rb, n, b, k, i;
    rb = (w + 7) / 8;
    a = BASE + 32'(code) * 32'(bpg);
    dq.delete();
    aq.delete();
    wr(glyph_resolver_pkg::IDX_CTRL, {30'h0, sz});
    wr(glyph_resolver_pkg::IDX_CODE, {16'h0, code});
    rdchk(glyph_resolver_pkg::IDX_STAT, 32'h1, 1'b0);
    wr(glyph_resolver_pkg::IDX_CODE, {16'h0, ~code});
    rdchk(glyph_resolver_pkg::IDX_CODE, {16'h0, code}, 1'b0);
    for (i = 0; i < 20000 && busy_o !== 1'b0; i++) @(negedge clk_i);
    if (i == 20000) hang("glyph");
    rdchk(glyph_resolver_pkg::IDX_ADDR, a, 1'b0);
    check(34'(aq.size()), 34'(bpg), "byte count");
    check(34'(dq.size()), 34'(w * (bpg / rb)), "dot count");
    if (aq.size() != bpg || dq.size() != w * (bpg / rb)) return;
    i = 0;
    for (b = 0; b < bpg; b++) begin
      check({2'b00, aq[b]}, {2'b00, a + 32'(b)}, "fetch addr");
      d = (a[7:0] + 8'(b)) ^ (a + 32'(b)) >> 8 ^ (a + 32'(b)) >> 16 ^ 8'h5A;
      n = (w == 12 && b % 2 == 1) ? 4 : 8;
      for (k = 0; k < n; k++) begin
        check(dq[i], {5'((b % rb) * 8 + k), 5'(b / rb), d[7-k] ? FG : BG}, "dot");
        i++;
      end
    end
  endtask : t_glyph

  // reset in mid-glyph: the engine stops and registers return to reset values
  task automatic t_reset;
    wr(glyph_resolver_pkg::IDX_CODE, 32'h0000_0005);
    repeat (20) @(posedge clk_i);
    check({33'h0, busy_o}, 34'h1, "busy before reset");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    check({33'h0, busy_o}, 34'h0, "busy after reset");
    rdchk(glyph_resolver_pkg::IDX_STAT, 32'h0, 1'b0);
    rdchk(glyph_resolver_pkg::IDX_FG0, 32'h0, 1'b0);
    rdchk(glyph_resolver_pkg::IDX_BG2, 32'h0, 1'b0);
  endtask : t_reset

  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_glyph(glyph_resolver_pkg::SIZE_16, 16'h0001, 16, 8);
    stall <= 1'b1;
    t_glyph(glyph_resolver_pkg::SIZE_16, 16'h8001, 32, 16);
    t_glyph(glyph_resolver_pkg::SIZE_24, 16'h7FFF, 48, 12);
    stall <= 1'b0;
    t_glyph(glyph_resolver_pkg::SIZE_24, 16'h8000, 72, 24);
    t_glyph(glyph_resolver_pkg::SIZE_32, 16'h0000, 64, 16);
    stall <= 1'b1;
    t_glyph(glyph_resolver_pkg::SIZE_32, 16'hFFFF, 128, 32);
    t_glyph(2'h3, 16'h0002, 16, 8);
    t_reset();
    close_out();
  end
endmodule : testbench
`default_nettype wire

// ===== hw/user_glyph_code_resolver.sv
// Notes on behaviour
// RQ1 - half-width glyphs come in 8x16, 12x24 and 16x32 dots
// RQ2 - full-width glyphs come in 16x16, 24x24 and 32x32 dots
// RQ3 - codes 0000h to 7FFFh select half-width glyphs
// RQ4 - codes 8000h to FFFFh select full-width glyphs
// RQ5 - host writes only the code; device turns it into absolute glyph address
// RQ6 - device fetches glyph bytes and writes rendered dots to display memory
// RQ7 - set dots are painted in the foreground colour from D2h..D4h
// RQ8 - cleared dots are painted in the background colour from D5h..D7h
// RQ9 - 8x16 glyph is 16 bytes at base plus code times 16
// RQ10 - 16x16 glyph is 32 bytes at base plus code times 32
// RQ11 - 12x24 glyph is 48 bytes at base plus code times 48
// RQ12 - 12x24 glyphs ignore the low nibble of odd-numbered bytes
// RQ13 - 24x24 glyph is 72 bytes at base plus code times 72
// RQ14 - 16x32 glyph is 64 bytes at base plus code times 64
// RQ15 - 32x32 glyph is 128 bytes at base plus code times 128
// RQ16 - bytes read row by row, ceil(width/8) per row, msb is leftmost dot
// RQ17 - multiplier picked from size select and half/full code range
`default_nettype none
module user_glyph_code_resolver #(
  parameter int ADDR_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic mem_req_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output logic [4:0] pix_x_o,
  output logic [4:0] pix_y_o,
  output logic [23:0] pix_colour_o,
  output logic busy_o
);
  logic [7:0] fg_ff [3];
  logic [7:0] bg_ff [3];
  logic [7:0] nxt_fg [3];
  logic [7:0] nxt_bg [3];
  logic [ADDR_W-1:0] base_ff, nxt_base;
  logic [1:0] size_ff, nxt_size;
  logic [15:0] code_ff, nxt_code;
  logic [31:0] prdata_ff, nxt_prdata;
  logic err_ff, nxt_err;
  logic setup, wr_acc, code_wr;
  logic [9:0] idx;
  glyph_resolver_pkg::eng_state_t state_ff, nxt_state;
  logic [ADDR_W-1:0] gaddr_ff, nxt_gaddr;
  logic [ADDR_W-1:0] maddr_ff, nxt_maddr;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] byte_ff, nxt_byte;
  logic [2:0] dot_ff, nxt_dot;
  logic [5:0] x_ff, nxt_x;
  logic [4:0] y_ff, nxt_y;
  logic half_ff, nxt_half;
  logic [1:0] esize_ff, nxt_esize;
  logic [7:0] bpg;
  logic [5:0] width;
  logic last_byte;

  assign idx = paddr_i[11:2];
  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign code_wr = wr_acc && (idx == glyph_resolver_pkg::IDX_CODE) && (state_ff == glyph_resolver_pkg::ST_IDLE);
  // zero wait states: read data is captured in the setup cycle
  assign pready_o = psel_i && penable_i;
  assign prdata_o = prdata_ff;
  assign pslverr_o = pready_o && err_ff;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_fg[i] = fg_ff[i];
      nxt_bg[i] = bg_ff[i];
    end
    nxt_base = base_ff;
    nxt_size = size_ff;
    nxt_code = code_ff;
    nxt_prdata = prdata_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_err = 1'b0;
      nxt_prdata = 32'h0000_0000;
      unique case (idx)
        glyph_resolver_pkg::IDX_FG0: nxt_prdata = {24'h00_0000, fg_ff[0]};
        glyph_resolver_pkg::IDX_FG1: nxt_prdata = {24'h00_0000, fg_ff[1]};
        glyph_resolver_pkg::IDX_FG2: nxt_prdata = {24'h00_0000, fg_ff[2]};
        glyph_resolver_pkg::IDX_BG0: nxt_prdata = {24'h00_0000, bg_ff[0]};
        glyph_resolver_pkg::IDX_BG1: nxt_prdata = {24'h00_0000, bg_ff[1]};
        glyph_resolver_pkg::IDX_BG2: nxt_prdata = {24'h00_0000, bg_ff[2]};
        glyph_resolver_pkg::IDX_BASE: nxt_prdata = 32'(base_ff);
        glyph_resolver_pkg::IDX_CTRL: nxt_prdata = {30'h0000_0000, size_ff};
        glyph_resolver_pkg::IDX_CODE: nxt_prdata = {16'h0000, code_ff};
        glyph_resolver_pkg::IDX_STAT: nxt_prdata = {31'h0000_0000, busy_o};
        glyph_resolver_pkg::IDX_ADDR: nxt_prdata = 32'(gaddr_ff);
        default: nxt_err = 1'b1;
      endcase
    end
    if (wr_acc) begin
      unique case (idx)
        glyph_resolver_pkg::IDX_FG0: nxt_fg[0] = pwdata_i[7:0]; // [RQ7]
        glyph_resolver_pkg::IDX_FG1: nxt_fg[1] = pwdata_i[7:0]; // [RQ7]
        glyph_resolver_pkg::IDX_FG2: nxt_fg[2] = pwdata_i[7:0]; // [RQ7]
        glyph_resolver_pkg::IDX_BG0: nxt_bg[0] = pwdata_i[7:0]; // [RQ8]
        glyph_resolver_pkg::IDX_BG1: nxt_bg[1] = pwdata_i[7:0]; // [RQ8]
        glyph_resolver_pkg::IDX_BG2: nxt_bg[2] = pwdata_i[7:0]; // [RQ8]
        glyph_resolver_pkg::IDX_BASE: nxt_base = ADDR_W'(pwdata_i);
        glyph_resolver_pkg::IDX_CTRL: nxt_size = pwdata_i[1:0];
        // a code written while busy is dropped; software polls the busy bit
        glyph_resolver_pkg::IDX_CODE: if (code_wr) nxt_code = pwdata_i[15:0]; // [RQ5]
        default: nxt_err = err_ff;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        fg_ff[i] <= glyph_resolver_pkg::RST_COLOUR;
        bg_ff[i] <= glyph_resolver_pkg::RST_COLOUR;
      end
      base_ff <= ADDR_W'(glyph_resolver_pkg::RST_BASE);
      size_ff <= glyph_resolver_pkg::RST_SIZE;
      code_ff <= 16'h0000;
      prdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      fg_ff <= nxt_fg;
      bg_ff <= nxt_bg;
      base_ff <= nxt_base;
      size_ff <= nxt_size;
      code_ff <= nxt_code;
      prdata_ff <= nxt_prdata;
      err_ff <= nxt_err;
    end
  end

  // geometry from the latched size class and code range
  always_comb begin
    unique case (esize_ff)
      glyph_resolver_pkg::SIZE_24: begin // [RQ1] [RQ2]
        bpg = half_ff ? glyph_resolver_pkg::BPG_12X24 : glyph_resolver_pkg::BPG_24X24; // [RQ11] [RQ13] [RQ17]
        width = half_ff ? glyph_resolver_pkg::W_12 : glyph_resolver_pkg::W_24;
      end
      glyph_resolver_pkg::SIZE_32: begin
        bpg = half_ff ? glyph_resolver_pkg::BPG_16X32 : glyph_resolver_pkg::BPG_32X32; // [RQ14] [RQ15] [RQ17]
        width = half_ff ? glyph_resolver_pkg::W_16 : glyph_resolver_pkg::W_32;
      end
      default: begin
        // the spare size code falls back to the 16-dot height
        bpg = half_ff ? glyph_resolver_pkg::BPG_8X16 : glyph_resolver_pkg::BPG_16X16; // [RQ9] [RQ10] [RQ17]
        width = half_ff ? glyph_resolver_pkg::W_8 : glyph_resolver_pkg::W_16;
      end
    endcase
  end

  assign last_byte = (ptr_ff == bpg - 8'h01);

  always_comb begin
    nxt_state = state_ff;
    nxt_gaddr = gaddr_ff;
    nxt_maddr = maddr_ff;
    nxt_ptr = ptr_ff;
    nxt_byte = byte_ff;
    nxt_dot = dot_ff;
    nxt_x = x_ff;
    nxt_y = y_ff;
    nxt_half = half_ff;
    nxt_esize = esize_ff;
    unique case (state_ff)
      glyph_resolver_pkg::ST_IDLE: begin
        if (code_wr) begin
          nxt_half = !pwdata_i[15]; // [RQ3] [RQ4]
          nxt_esize = size_ff;
          nxt_state = glyph_resolver_pkg::ST_CALC;
        end
      end
      glyph_resolver_pkg::ST_CALC: begin
        nxt_gaddr = ADDR_W'(base_ff + ADDR_W'(code_ff) * ADDR_W'(bpg)); // [RQ5]
        nxt_maddr = nxt_gaddr;
        nxt_ptr = 8'h00;
        nxt_x = 6'h00;
        nxt_y = 5'h00;
        nxt_state = glyph_resolver_pkg::ST_FETCH;
      end
      glyph_resolver_pkg::ST_FETCH: begin
        if (mem_ack_i) begin
          nxt_byte = mem_rdata_i; // [RQ6]
          // only the high nibble of odd bytes carries dots at 12 wide
          nxt_dot = (width == glyph_resolver_pkg::W_12 && ptr_ff[0])
            ? glyph_resolver_pkg::LAST_DOT_NIB : glyph_resolver_pkg::LAST_DOT_FULL; // [RQ12]
          nxt_state = glyph_resolver_pkg::ST_DRAW;
        end
      end
      glyph_resolver_pkg::ST_DRAW: begin
        if (pix_ready_i) begin
          nxt_byte = {byte_ff[6:0], 1'b0}; // [RQ16]
          nxt_x = x_ff + 6'h01;
          nxt_dot = dot_ff - 3'h1;
          if (dot_ff == 3'h0) nxt_state = glyph_resolver_pkg::ST_NEXT;
        end
      end
      glyph_resolver_pkg::ST_NEXT: begin
        nxt_ptr = ptr_ff + 8'h01;
        nxt_maddr = maddr_ff + ADDR_W'(1);
        if (x_ff == width) begin // [RQ16]
          nxt_x = 6'h00;
          nxt_y = y_ff + 5'h01;
        end
        nxt_state = last_byte ? glyph_resolver_pkg::ST_IDLE : glyph_resolver_pkg::ST_FETCH;
      end
      default: nxt_state = glyph_resolver_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= glyph_resolver_pkg::ST_IDLE;
      gaddr_ff <= '0;
      maddr_ff <= '0;
      ptr_ff <= 8'h00;
      byte_ff <= 8'h00;
      dot_ff <= 3'h0;
      x_ff <= 6'h00;
      y_ff <= 5'h00;
      half_ff <= 1'b1;
      esize_ff <= glyph_resolver_pkg::RST_SIZE;
    end else begin
      state_ff <= nxt_state;
      gaddr_ff <= nxt_gaddr;
      maddr_ff <= nxt_maddr;
      ptr_ff <= nxt_ptr;
      byte_ff <= nxt_byte;
      dot_ff <= nxt_dot;
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      half_ff <= nxt_half;
      esize_ff <= nxt_esize;
    end
  end

  assign busy_o = (state_ff != glyph_resolver_pkg::ST_IDLE);
  assign mem_req_o = (state_ff == glyph_resolver_pkg::ST_FETCH);
  assign mem_addr_o = maddr_ff;
  assign pix_valid_o = (state_ff == glyph_resolver_pkg::ST_DRAW);
  assign pix_x_o = x_ff[4:0];
  assign pix_y_o = y_ff;
  assign pix_colour_o = byte_ff[7] ? {fg_ff[2], fg_ff[1], fg_ff[0]} // [RQ7]
                                   : {bg_ff[2], bg_ff[1], bg_ff[0]}; // [RQ8]

  // reference for the checks below, kept apart from the engine's own table and shifter
  logic [7:0] ref_byte_ff, nxt_ref_byte;
  logic [3:0] ref_dot_ff, nxt_ref_dot;
  logic [7:0] ref_cnt_ff, nxt_ref_cnt;
  logic [5:0] ref_w, ref_h;
  logic [7:0] ref_bytes;

  // glyph shape from size class and code range; bytes come from rows times whole bytes per row
  always_comb begin
    unique case (esize_ff)
      glyph_resolver_pkg::SIZE_24: begin // [RQ1] [RQ2]
        ref_w = half_ff ? glyph_resolver_pkg::W_12 : glyph_resolver_pkg::W_24;
        ref_h = glyph_resolver_pkg::W_24;
      end
      glyph_resolver_pkg::SIZE_32: begin // [RQ1] [RQ2]
        ref_w = half_ff ? glyph_resolver_pkg::W_16 : glyph_resolver_pkg::W_32;
        ref_h = glyph_resolver_pkg::W_32;
      end
      default: begin
        ref_w = half_ff ? glyph_resolver_pkg::W_8 : glyph_resolver_pkg::W_16;
        ref_h = glyph_resolver_pkg::W_16;
      end
    endcase
    // half-width glyphs are twice as tall as wide, full-width ones square
    ref_bytes = 8'(ref_h) * 8'((ref_w + 6'h07) >> 3); // [RQ16] [RQ17]
  end

  always_comb begin
    nxt_ref_byte = ref_byte_ff;
    nxt_ref_dot = ref_dot_ff;
    nxt_ref_cnt = ref_cnt_ff;
    if (code_wr) begin
      nxt_ref_cnt = 8'h00;
    end else if (state_ff == glyph_resolver_pkg::ST_FETCH && mem_ack_i) begin
      nxt_ref_byte = mem_rdata_i; // [RQ6]
      nxt_ref_dot = 4'h0;
      nxt_ref_cnt = ref_cnt_ff + 8'h01;
    end else if (pix_valid_o && pix_ready_i) begin
      nxt_ref_dot = ref_dot_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_byte_ff <= 8'h00;
      ref_dot_ff <= 4'h0;
      ref_cnt_ff <= 8'h00;
    end else begin
      ref_byte_ff <= nxt_ref_byte;
      ref_dot_ff <= nxt_ref_dot;
      ref_cnt_ff <= nxt_ref_cnt;
    end
  end

  // checks
  a_calc_address: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ5]
    state_ff == glyph_resolver_pkg::ST_CALC
      |=> gaddr_ff == ADDR_W'($past(base_ff) + ADDR_W'(code_ff) * ADDR_W'($past(ref_bytes))))
    else $error("glyph address not base plus code times size");
  a_half_range: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ3]
    code_wr && !pwdata_i[15] |=> half_ff)
    else $error("low code not taken as half width");
  a_full_range: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ4]
    code_wr && pwdata_i[15] |=> !half_ff)
    else $error("high code not taken as full width");
  a_bpg_select: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ17]
    busy_o |-> bpg == ref_bytes)
    else $error("bytes per glyph do not match the glyph shape");
  a_nibble_skip: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ12]
    state_ff == glyph_resolver_pkg::ST_FETCH && mem_ack_i && width == 6'h0C && ptr_ff[0] |=> dot_ff == 3'h3)
    else $error("odd 12-wide byte not trimmed to four dots");
  a_fg_paint: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ7]
    pix_valid_o && ref_byte_ff[3'h7 - ref_dot_ff[2:0]] |-> pix_colour_o == {fg_ff[2], fg_ff[1], fg_ff[0]})
    else $error("set dot not in foreground colour");
  a_bg_paint: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ8]
    pix_valid_o && !ref_byte_ff[3'h7 - ref_dot_ff[2:0]] |-> pix_colour_o == {bg_ff[2], bg_ff[1], bg_ff[0]})
    else $error("cleared dot not in background colour");
  a_row_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ16]
    state_ff == glyph_resolver_pkg::ST_NEXT && x_ff == width |=> x_ff == 6'h00 && y_ff == $past(y_ff) + 5'h01)
    else $error("row did not wrap at glyph width");
  a_fetch_seq: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ6]
    state_ff == glyph_resolver_pkg::ST_NEXT && !last_byte |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + ADDR_W'(1))
    else $error("next glyph byte not fetched in sequence");
  c_half_glyph: cover property (@(posedge clk_i) disable iff (!rst_n_i) code_wr && !pwdata_i[15]);
  c_full_glyph: cover property (@(posedge clk_i) disable iff (!rst_n_i) code_wr && pwdata_i[15]);
  c_glyph_done: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_ff == glyph_resolver_pkg::ST_NEXT && last_byte);
  c_stall: cover property (@(posedge clk_i) disable iff (!rst_n_i) pix_valid_o && !pix_ready_i);
  c_nibble_trim: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_ff == glyph_resolver_pkg::ST_NEXT && ref_dot_ff == 4'h4);
  a_byte_total: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ9] [RQ10] [RQ11] [RQ13] [RQ14] [RQ15]
    state_ff == glyph_resolver_pkg::ST_NEXT && last_byte |-> ref_cnt_ff == ref_bytes)
    else $error("glyph ended after wrong number of bytes");
  a_no_overrun: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ9] [RQ15]
    state_ff == glyph_resolver_pkg::ST_NEXT && !last_byte |-> ref_cnt_ff < ref_bytes)
    else $error("glyph ran past its last byte");
  // sequence numbers start at zero, so an odd byte leaves the count even
  a_dots_per_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ12] [RQ16]
    state_ff == glyph_resolver_pkg::ST_NEXT
      |-> ref_dot_ff == ((ref_w == glyph_resolver_pkg::W_12 && !ref_cnt_ff[0]) ? 4'h4 : 4'h8))
    else $error("wrong number of dots drawn from a byte");
  a_x_in_row: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ16]
    pix_valid_o |-> {1'b0, pix_x_o} < ref_w)
    else $error("dot placed outside the glyph width");
  // colour is left out: software may rewrite a colour register during a stall
  a_pix_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ6]
    pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_x_o) && $stable(pix_y_o))
    else $error("dot moved while the display side stalled");
  a_req_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ6]
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch dropped or moved before its answer");
  a_busy_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ5]
    wr_acc && idx == glyph_resolver_pkg::IDX_CODE && busy_o |=> $stable(code_ff))
    else $error("code written while busy was taken");
  a_first_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ5] [RQ6]
    code_wr |-> ##2 mem_req_o && mem_addr_o == gaddr_ff)
    else $error("first glyph byte not fetched from the resolved address");
endmodule : user_glyph_code_resolver
`default_nettype wire

// ===== include/glyph_resolver_pkg.sv
`default_nettype none
package glyph_resolver_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_FG0 = 10'h0D2;
  localparam logic [9:0] IDX_FG1 = 10'h0D3;
  localparam logic [9:0] IDX_FG2 = 10'h0D4;
  localparam logic [9:0] IDX_BG0 = 10'h0D5;
  localparam logic [9:0] IDX_BG1 = 10'h0D6;
  localparam logic [9:0] IDX_BG2 = 10'h0D7;
  localparam logic [9:0] IDX_BASE = 10'h0D8;
  localparam logic [9:0] IDX_CTRL = 10'h0D9;
  localparam logic [9:0] IDX_CODE = 10'h0DA;
  localparam logic [9:0] IDX_STAT = 10'h0DB;
  localparam logic [9:0] IDX_ADDR = 10'h0DC;
  // reset values
  localparam logic [7:0] RST_COLOUR = 8'h00;
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [1:0] RST_SIZE = 2'h0;
  // size select: height class
  localparam logic [1:0] SIZE_16 = 2'h0;
  localparam logic [1:0] SIZE_24 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  // bytes per glyph
  localparam logic [7:0] BPG_8X16 = 8'h10;
  localparam logic [7:0] BPG_16X16 = 8'h20;
  localparam logic [7:0] BPG_12X24 = 8'h30;
  localparam logic [7:0] BPG_24X24 = 8'h48;
  localparam logic [7:0] BPG_16X32 = 8'h40;
  localparam logic [7:0] BPG_32X32 = 8'h80;
  // glyph widths in dots
  localparam logic [5:0] W_8 = 6'h08;
  localparam logic [5:0] W_12 = 6'h0C;
  localparam logic [5:0] W_16 = 6'h10;
  localparam logic [5:0] W_24 = 6'h18;
  localparam logic [5:0] W_32 = 6'h20;
  // dots used in a byte: full, or high nibble only
  localparam logic [2:0] LAST_DOT_FULL = 3'h7;
  localparam logic [2:0] LAST_DOT_NIB = 3'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CALC = 3'b001,
    ST_FETCH = 3'b011,
    ST_DRAW = 3'b010,
    ST_NEXT = 3'b110
  } eng_state_t;
endpackage : glyph_resolver_pkg
`default_nettype wire
